// ===== src/pcxb_top.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Function
// [RULE1] Fixed rank order, uart highest
// [RULE2] Enabled function takes lowest free pin
// [RULE3] Assigned pins are passed over afterwards
// [RULE4] Skipped pins treated as occupied
// [RULE5] Uart fixed on P0.4 and P0.5
// [RULE6] SMBus takes data and clock pins
// [RULE7] Uart takes both transmit and receive
// [RULE8] Leftover pins act as general-purpose
// [RULE9] Slave select pinned only in 4-wire
// [RULE10] Only P0.0-P2.7 are crossbar pins
// [RULE11] Pin transitions raise interrupt or wake
// [RULE12] Events work on skipped and crossbar pins
// [RULE13] No events on analog pins
// [RULE14] Software skips pins used outside crossbar
// [RULE15] Software skips pins meant for GPIO
// [RULE16] Software skips pins not bonded out
// [RULE17] Disabled crossbar: all drivers off
// [RULE18] Mapping recomputed, outputs next cycle
module pcxb_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pcxb_pkg::AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [pcxb_pkg::NSIG-1:0] FUNC_OUT,
    input wire logic [pcxb_pkg::NSIG-1:0] FUNC_DRIVE,
    output logic [pcxb_pkg::NSIG-1:0] FUNC_IN,
    input wire logic [pcxb_pkg::NPIN-1:0] PIN_IN,
    output logic [pcxb_pkg::NPIN-1:0] PIN_OUT,
    output logic [pcxb_pkg::NPIN-1:0] PIN_OE_N,
    output logic [pcxb_pkg::NPIN-1:0] PIN_PULLUP,
    output logic IRQ,
    output logic WAKE
);
    import pcxb_pkg::*;

    logic [SL_W-1:0] sel_low;
    logic [SH_W-1:0] sel_high;
    logic [NPIN-1:0] skip;
    logic [NPIN-1:0] in_mode;
    logic [1:0] spi_mode;
    logic [NPIN-1:0] gpio_out;
    logic [NPIN-1:0] gpio_dir;
    logic [NPIN-1:0] ev_sel;
    logic [NPIN-1:0] ev_status;
    logic [NPIN-1:0] ev_mask;

    logic [NSIG-1:0] req;
    logic [NSIG-1:0][NPIN-1:0] next_sig_onehot;
    logic [NPIN-1:0] next_pin_used;
    logic [NPIN-1:0][SIGW-1:0] next_pin_sig;
    logic [NSIG-1:0][NPIN-1:0] sig_onehot;
    logic [NPIN-1:0] pin_used;

    logic [NPIN-1:0] pin_sync;
    logic [NPIN-1:0] ev_pulse;
    logic [NPIN-1:0] next_pin_out;
    logic [NPIN-1:0] next_pin_oe_n;
    logic [NPIN-1:0] next_pin_pullup;
    logic xbar_on;

    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic [31:0] next_rdata;

    assign xbar_on = sel_high[SH_ENABLE];

    // Enables expand into per-signal requests; pairs travel together.
    always_comb begin
        req = '0;
        req[SIG_UART_TX] = sel_low[SL_UART]; // [RULE7]
        req[SIG_UART_RX] = sel_low[SL_UART]; // [RULE7]
        req[SIG_SPI_SCK] = sel_low[SL_SPI];
        req[SIG_SPI_MISO] = sel_low[SL_SPI];
        req[SIG_SPI_MOSI] = sel_low[SL_SPI];
        req[SIG_SPI_NSS] = sel_low[SL_SPI] &&
                           (spi_mode != SPI_MODE_3WIRE); // [RULE9]
        req[SIG_SMB_SDA] = sel_low[SL_SMB]; // [RULE6]
        req[SIG_SMB_SCL] = sel_low[SL_SMB]; // [RULE6]
        req[SIG_CMP_SYNC] = sel_low[SL_CMP];
        req[SIG_CMP_ASYNC] = sel_low[SL_CMPA];
        req[SIG_SYSCLK] = sel_low[SL_SYSCLK];
        for (int c = 0; c < 3; c++) begin
            req[SIG_CEX0 + c] =
                (32'(sel_high[SH_CEX_HI:SH_CEX_LO]) > c);
        end
        req[SIG_ECI] = sel_high[SH_ECI];
        req[SIG_TMRA] = sel_high[SH_TMRA];
        req[SIG_TMRB] = sel_high[SH_TMRB];
    end

    // The walk only spans the 24 crossbar pins P0.0 to P2.7.
    pcxb_alloc u_alloc ( // [RULE10]
        .req(req),
        .skip(skip),
        .sig_onehot(next_sig_onehot),
        .pin_used(next_pin_used),
        .pin_sig(next_pin_sig)
    );

    pcxb_event u_event (
        .clk(CLK),
        .rst_n(RST_N),
        .pin_in(PIN_IN),
        .digital(in_mode),
        .ev_sel(ev_sel),
        .pin_sync(pin_sync),
        .ev_pulse(ev_pulse)
    );

    // The map is combinational from the settings and lands one edge later.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sig_onehot <= '0;
            pin_used <= RST_ZERO24;
        end else begin
            sig_onehot <= next_sig_onehot; // [RULE18]
            pin_used <= next_pin_used; // [RULE18]
        end
    end

    // Per-pin drive: a routed function, else a general-purpose pin.
    genvar p;
    generate
        for (p = 0; p < NPIN; p++) begin : g_pin
            always_comb begin
                next_pin_out[p] = 1'b0;
                next_pin_oe_n[p] = 1'b1;
                next_pin_pullup[p] = 1'b0;
                if (!xbar_on) begin
                    next_pin_pullup[p] = in_mode[p]; // [RULE17]
                end else if (!in_mode[p]) begin
                    // Analog pins keep driver and pull-up off.
                    next_pin_oe_n[p] = 1'b1;
                end else if (next_pin_used[p]) begin
                    next_pin_out[p] = FUNC_OUT[next_pin_sig[p]];
                    next_pin_oe_n[p] = ~FUNC_DRIVE[next_pin_sig[p]];
                    next_pin_pullup[p] = ~sel_high[SH_WEAKPUD];
                end else begin
                    next_pin_out[p] = gpio_out[p]; // [RULE8]
                    next_pin_oe_n[p] = ~gpio_dir[p]; // [RULE8]
                    next_pin_pullup[p] = ~sel_high[SH_WEAKPUD];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PIN_OUT <= RST_ZERO24;
            PIN_OE_N <= ~RST_ZERO24;
            PIN_PULLUP <= RST_IN_MODE;
        end else begin
            PIN_OUT <= next_pin_out; // [RULE18]
            PIN_OE_N <= next_pin_oe_n; // [RULE17] [RULE18]
            PIN_PULLUP <= next_pin_pullup;
        end
    end

    // Peripheral inputs see the synchronised level of their own pin.
    genvar s;
    generate
        for (s = 0; s < NSIG; s++) begin : g_in
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    FUNC_IN[s] <= 1'b0;
                end else begin
                    FUNC_IN[s] <= xbar_on &&
                                  |(sig_onehot[s] & pin_sync & in_mode);
                end
            end
        end
    endgenerate

    // APB slave: zero wait states; unmapped offsets raise PSLVERR.
    assign PREADY = 1'b1;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;

    always_comb begin
        addr_hit = 1'b1;
        next_rdata = RD_ZERO;
        unique case (PADDR)
            OFS_SEL_LOW: next_rdata[SL_W-1:0] = sel_low;
            OFS_SEL_HIGH: next_rdata[SH_W-1:0] = sel_high;
            OFS_SKIP: next_rdata[NPIN-1:0] = skip;
            OFS_IN_MODE: next_rdata[NPIN-1:0] = in_mode;
            OFS_SPI_MODE: next_rdata[1:0] = spi_mode;
            OFS_GPIO_OUT: next_rdata[NPIN-1:0] = gpio_out;
            OFS_GPIO_DIR: next_rdata[NPIN-1:0] = gpio_dir;
            OFS_EV_SEL: next_rdata[NPIN-1:0] = ev_sel;
            OFS_EV_STATUS: next_rdata[NPIN-1:0] = ev_status;
            OFS_EV_MASK: next_rdata[NPIN-1:0] = ev_mask;
            // Analog pins read back as zero.
            OFS_PIN_STATE: next_rdata[NPIN-1:0] = pin_sync & in_mode;
            OFS_ROUTE: next_rdata[NPIN-1:0] = pin_used;
            default: addr_hit = 1'b0;
        endcase
    end

    assign PRDATA = next_rdata;
    assign PSLVERR = PSEL && PENABLE && !addr_hit;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sel_low <= RST_SEL_LOW;
            sel_high <= RST_SEL_HIGH;
        end else if (wr_en && PADDR == OFS_SEL_LOW) begin
            sel_low <= PWDATA[SL_W-1:0];
        end else if (wr_en && PADDR == OFS_SEL_HIGH) begin
            sel_high <= PWDATA[SH_W-1:0];
            sel_high[SH_RSVD] <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            skip <= RST_ZERO24;
            in_mode <= RST_IN_MODE;
            spi_mode <= RST_SPI_MODE;
        end else if (wr_en) begin
            if (PADDR == OFS_SKIP) begin
                skip <= PWDATA[NPIN-1:0]; // [RULE14] [RULE15] [RULE16]
            end
            if (PADDR == OFS_IN_MODE) begin
                in_mode <= PWDATA[NPIN-1:0];
            end
            if (PADDR == OFS_SPI_MODE) begin
                spi_mode <= PWDATA[1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            gpio_out <= RST_ZERO24;
            gpio_dir <= RST_ZERO24;
        end else if (wr_en) begin
            if (PADDR == OFS_GPIO_OUT) begin
                gpio_out <= PWDATA[NPIN-1:0];
            end
            if (PADDR == OFS_GPIO_DIR) begin
                gpio_dir <= PWDATA[NPIN-1:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ev_sel <= RST_ZERO24;
            ev_mask <= RST_ZERO24;
        end else if (wr_en) begin
            if (PADDR == OFS_EV_SEL) begin
                ev_sel <= PWDATA[NPIN-1:0];
            end
            if (PADDR == OFS_EV_MASK) begin
                ev_mask <= PWDATA[NPIN-1:0];
            end
        end
    end

    // Reading the status clears it, but an edge in that cycle survives.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ev_status <= RST_ZERO24;
        end else if (rd_en && PADDR == OFS_EV_STATUS) begin
            ev_status <= ev_pulse; // [RULE11]
        end else begin
            ev_status <= ev_status | ev_pulse; // [RULE11]
        end
    end

    // Wake is a pulse so a sleeping core sees it without masking.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
            WAKE <= 1'b0;
        end else begin
            IRQ <= |((ev_status | ev_pulse) & ev_mask); // [RULE11]
            WAKE <= |ev_pulse; // [RULE11]
        end
    end

endmodule : pcxb_top
`default_nettype wire

// ===== shared/pcxb_pkg.sv
package pcxb_pkg;

    localparam int NPIN = 24;
    localparam int NSIG = 17;
    localparam int SIGW = 5;
    localparam int AW = 12;

    // Crossbar signals in falling priority; the index is the rank.
    localparam int SIG_UART_TX = 0;
    localparam int SIG_UART_RX = 1;
    localparam int SIG_SPI_SCK = 2;
    localparam int SIG_SPI_MISO = 3;
    localparam int SIG_SPI_MOSI = 4;
    localparam int SIG_SPI_NSS = 5;
    localparam int SIG_SMB_SDA = 6;
    localparam int SIG_SMB_SCL = 7;
    localparam int SIG_CMP_SYNC = 8;
    localparam int SIG_CMP_ASYNC = 9;
    localparam int SIG_SYSCLK = 10;
    localparam int SIG_CEX0 = 11;
    localparam int SIG_ECI = 14;
    localparam int SIG_TMRA = 15;
    localparam int SIG_TMRB = 16;

    // Fixed uart pins P0.4 and P0.5.
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;

    // Field positions of crossbar_select_low.
    localparam int SL_UART = 0;
    localparam int SL_SPI = 1;
    localparam int SL_SMB = 2;
    localparam int SL_SYSCLK = 3;
    localparam int SL_CMP = 4;
    localparam int SL_CMPA = 5;
    localparam int SL_W = 6;

    // Field positions of crossbar_select_high.
    localparam int SH_CEX_LO = 0;
    localparam int SH_CEX_HI = 1;
    localparam int SH_RSVD = 2;
    localparam int SH_ECI = 3;
    localparam int SH_TMRA = 4;
    localparam int SH_TMRB = 5;
    localparam int SH_ENABLE = 6;
    localparam int SH_WEAKPUD = 7;
    localparam int SH_W = 8;

    localparam logic [1:0] SPI_MODE_3WIRE = 2'h0;

    // Register byte offsets.
    localparam logic [AW-1:0] OFS_SEL_LOW = 12'h000;
    localparam logic [AW-1:0] OFS_SEL_HIGH = 12'h004;
    localparam logic [AW-1:0] OFS_SKIP = 12'h008;
    localparam logic [AW-1:0] OFS_IN_MODE = 12'h00C;
    localparam logic [AW-1:0] OFS_SPI_MODE = 12'h010;
    localparam logic [AW-1:0] OFS_GPIO_OUT = 12'h014;
    localparam logic [AW-1:0] OFS_GPIO_DIR = 12'h018;
    localparam logic [AW-1:0] OFS_EV_SEL = 12'h01C;
    localparam logic [AW-1:0] OFS_EV_STATUS = 12'h020;
    localparam logic [AW-1:0] OFS_EV_MASK = 12'h024;
    localparam logic [AW-1:0] OFS_PIN_STATE = 12'h028;
    localparam logic [AW-1:0] OFS_ROUTE = 12'h02C;

    // Reset values.
    localparam logic [NPIN-1:0] RST_ZERO24 = 24'h000000;
    localparam logic [NPIN-1:0] RST_IN_MODE = 24'hFFFFFF;
    localparam logic [SL_W-1:0] RST_SEL_LOW = 6'h00;
    localparam logic [SH_W-1:0] RST_SEL_HIGH = 8'h00;
    localparam logic [1:0] RST_SPI_MODE = 2'h0;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

endpackage : pcxb_pkg

// ===== src/pcxb_alloc.sv
`timescale 1ns/1ns
`default_nettype none
module pcxb_alloc (
    input wire logic [pcxb_pkg::NSIG-1:0] req,
    input wire logic [pcxb_pkg::NPIN-1:0] skip,
    output logic [pcxb_pkg::NSIG-1:0][pcxb_pkg::NPIN-1:0] sig_onehot,
    output logic [pcxb_pkg::NPIN-1:0] pin_used,
    output logic [pcxb_pkg::NPIN-1:0][pcxb_pkg::SIGW-1:0] pin_sig
);
    import pcxb_pkg::*;

    localparam logic [NPIN-1:0] ONE24 = 24'h000001;

    logic [NSIG:0][NPIN-1:0] occ;
    logic [NPIN-1:0] uart_pins;

    // The uart claims its pins even when they are skipped.
    assign uart_pins = (req[SIG_UART_TX] ? (ONE24 << UART_TX_PIN) : '0) |
                       (req[SIG_UART_RX] ? (ONE24 << UART_RX_PIN) : '0);
    assign occ[0] = skip | uart_pins; // [RULE4] [RULE5]

    genvar s;
    generate
        for (s = 0; s < NSIG; s++) begin : g_sig
            logic [NPIN-1:0] free;
            logic [NPIN-1:0] lowest;
            assign free = ~occ[s];
            assign lowest = free & (~free + ONE24); // [RULE2]
            if (s == SIG_UART_TX) begin : g_tx
                assign sig_onehot[s] = req[s] ? (ONE24 << UART_TX_PIN) : '0;
            end else if (s == SIG_UART_RX) begin : g_rx
                assign sig_onehot[s] = req[s] ? (ONE24 << UART_RX_PIN) : '0;
            end else begin : g_walk
                assign sig_onehot[s] = req[s] ? lowest : '0; // [RULE1]
            end
            assign occ[s+1] = occ[s] | sig_onehot[s]; // [RULE3]
        end
    endgenerate

    genvar p;
    generate
        for (p = 0; p < NPIN; p++) begin : g_pin
            always_comb begin
                pin_used[p] = 1'b0;
                pin_sig[p] = '0;
                for (int k = 0; k < NSIG; k++) begin
                    if (sig_onehot[k][p]) begin
                        pin_used[p] = 1'b1;
                        pin_sig[p] = SIGW'(k);
                    end
                end
            end
        end
    endgenerate

endmodule : pcxb_alloc
`default_nettype wire

// ===== src/pcxb_event.sv
`timescale 1ns/1ns
`default_nettype none
module pcxb_event (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pcxb_pkg::NPIN-1:0] pin_in,
    input wire logic [pcxb_pkg::NPIN-1:0] digital,
    input wire logic [pcxb_pkg::NPIN-1:0] ev_sel,
    output logic [pcxb_pkg::NPIN-1:0] pin_sync,
    output logic [pcxb_pkg::NPIN-1:0] ev_pulse
);
    import pcxb_pkg::*;

    logic [NPIN-1:0] meta;
    logic [NPIN-1:0] prev;
    // Pads idling high would look like a fresh edge once the pipeline fills
    // after reset, so edges count only after all three stages hold pad data.
    localparam int ARM_W = 3;
    logic [ARM_W-1:0] armed;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= RST_ZERO24;
            pin_sync <= RST_ZERO24;
        end else begin
            meta <= pin_in;
            pin_sync <= meta;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= RST_ZERO24;
            armed <= '0;
        end else begin
            prev <= pin_sync;
            armed <= {armed[ARM_W-2:0], 1'b1};
        end
    end

    // Any transition counts; skip state plays no part in eligibility.
    assign ev_pulse = (pin_sync ^ prev) & ev_sel & digital &
                      {NPIN{armed[ARM_W-1]}}; // [RULE11] [RULE12] [RULE13]

endmodule : pcxb_event
`default_nettype wire

// ===== dv/pcxb_props.sv
`timescale 1ns/1ns
`default_nettype none
module pcxb_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pcxb_pkg::AW-1:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [pcxb_pkg::NSIG-1:0] FUNC_IN,
    input wire logic [pcxb_pkg::NPIN-1:0] PIN_IN,
    input wire logic [pcxb_pkg::NPIN-1:0] PIN_OUT,
    input wire logic [pcxb_pkg::NPIN-1:0] PIN_OE_N,
    input wire logic [pcxb_pkg::NPIN-1:0] PIN_PULLUP,
    input wire logic IRQ,
    input wire logic WAKE
);
    import pcxb_pkg::*;
    default clocking dc @(posedge CLK);
    endclocking
    wire logic acc = PSEL && PENABLE;
    wire logic rd_st = acc && !PWRITE && PADDR == OFS_EV_STATUS;
    wire logic wr_msk = acc && PWRITE && PADDR == OFS_EV_MASK;

    a_ready_zero_wait: assert property (disable iff (!RST_N)
        acc |-> PREADY) else $error("access phase without ready");
    a_unmapped_refused: assert property (disable iff (!RST_N)
        acc && PADDR > OFS_ROUTE |-> PSLVERR && PRDATA == RD_ZERO)
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (disable iff (!RST_N)
        acc && PADDR <= OFS_ROUTE && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("error on a mapped register");
    a_reset_drive_off: assert property (
        !RST_N |=> &PIN_OE_N && PIN_OUT == '0)
        else $error("pad driven in reset");
    a_reset_quiet: assert property (!RST_N |=>
        FUNC_IN == '0 && !IRQ && !WAKE && &PIN_PULLUP)
        else $error("outputs not quiet in reset");
    // Quiet pads for six cycles leave nothing in the sync pipeline.
    a_wake_needs_edge: assert property (disable iff (!RST_N)
        $stable(PIN_IN) [*6] |=> !WAKE) else $error("wake without edge");
    a_irq_has_cause: assert property (disable iff (!RST_N)
        $rose(IRQ) |-> WAKE || $past(wr_msk) || $past(wr_msk, 2))
        else $error("interrupt without event");
    a_irq_read_clear: assert property (disable iff (!RST_N)
        $stable(PIN_IN) [*6] ##0 rd_st |=> ##1 !IRQ)
        else $error("interrupt kept after status read");
endmodule : pcxb_props
`default_nettype wire

// ===== dv/pcxb_periph.sv
`timescale 1ns/1ns
`default_nettype none
module pcxb_periph (
    input wire logic [pcxb_pkg::NSIG-1:0] pat,
    input wire logic [pcxb_pkg::NPIN-1:0] ext,
    input wire logic [pcxb_pkg::NPIN-1:0] pin_out,
    input wire logic [pcxb_pkg::NPIN-1:0] pin_oe_n,
    output logic [pcxb_pkg::NSIG-1:0] func_out,
    output logic [pcxb_pkg::NSIG-1:0] func_drive,
    output logic [pcxb_pkg::NPIN-1:0] pin_in
);
    import pcxb_pkg::*;
    assign func_out = pat;
    // Receive and timer inputs only listen; the bus lines are open drain,
    // so they drive only while pulling low.
    assign func_drive = {3'h0, 6'h3F, ~pat[SIG_SMB_SCL], ~pat[SIG_SMB_SDA],
        4'hF, 1'b0, 1'b1};
    // The board drives every pad that the device leaves released.
    assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule : pcxb_periph
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pcxb_pkg::*;
    logic clk, irq, errv, pready, pslverr, wake;
    logic [NPIN-1:0] ppu;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rdv;
    logic [NSIG-1:0] pat = '0;
    logic [NSIG-1:0] fout, fdrv, fin;
    logic [NPIN-1:0] ext = '0;
    logic [NPIN-1:0] pin_in, pout, poe_n, skip, im, gpo, gdir, eo, eoe, er;
    logic [4:0] emap [NPIN];
    logic [5:0] sl;
    logic [7:0] sh;
    logic [1:0] sm;
    logic [31:0] seed = 32'h13BBF102;
    int n_errors = 0;
    int check_count = 0;
    logic [39:0] corner [4] = '{{6'h3F, 8'h47, 24'h000000, 2'h1},
        {6'h3F, 8'h7B, 24'h00010C, 2'h0}, {6'h01, 8'h40, 24'hFFFFFF, 2'h0},
        {6'h06, 8'h43, 24'hFFFFF0, 2'h2}};

    pcxb_top i_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FUNC_OUT(fout),
        .FUNC_DRIVE(fdrv), .FUNC_IN(fin), .PIN_IN(pin_in), .PIN_OUT(pout),
        .PIN_OE_N(poe_n), .PIN_PULLUP(ppu), .IRQ(irq), .WAKE(wake));
    pcxb_periph i_per (.pat(pat), .ext(ext), .pin_out(pout),
        .pin_oe_n(poe_n), .func_out(fout), .func_drive(fdrv),
        .pin_in(pin_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [AW-1:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask : rd

    task automatic expect_map();
        logic [NSIG-1:0] rq;
        logic [NPIN-1:0] used;
        logic [1:0] n;
        n = sh[1:0];
        // Listed from the lowest rank up to the uart.
        rq = {sh[SH_TMRB], sh[SH_TMRA], sh[SH_ECI], n == 2'h3, n > 2'h1,
            n > 2'h0, sl[SL_SYSCLK], sl[SL_CMPA], sl[SL_CMP], {2{sl[SL_SMB]}},
            sl[SL_SPI] && sm != SPI_MODE_3WIRE, {3{sl[SL_SPI]}},
            {2{sl[SL_UART]}}};
        used = skip;
        for (int p = 0; p < NPIN; p++) emap[p] = 5'h1F;
        if (rq[SIG_UART_TX]) begin
            emap[UART_TX_PIN] = 5'(SIG_UART_TX);
            emap[UART_RX_PIN] = 5'(SIG_UART_RX);
            used[UART_TX_PIN] = 1'b1;
            used[UART_RX_PIN] = 1'b1;
        end
        for (int s = SIG_SPI_SCK; s < NSIG; s++) begin
            for (int p = 0; p < NPIN; p++) begin
                if (rq[s] && !used[p]) begin
                    emap[p] = 5'(s);
                    used[p] = 1'b1;
                    rq[s] = 1'b0;
                end
            end
        end
        for (int p = 0; p < NPIN; p++) begin
            er[p] = emap[p] != 5'h1F;
            eo[p] = 1'b0;
            eoe[p] = 1'b1;
            if (sh[SH_ENABLE] && im[p] && er[p]) begin
                eo[p] = fout[emap[p]];
                eoe[p] = ~fdrv[emap[p]];
            end else if (sh[SH_ENABLE] && im[p]) begin
                eo[p] = gpo[p];
                eoe[p] = ~gdir[p];
            end
        end
    endtask : expect_map

    task automatic cfg();
        logic [NPIN-1:0] m;
        wr(OFS_SEL_LOW, 32'(sl));
        wr(OFS_SEL_HIGH, 32'(sh));
        wr(OFS_SKIP, 32'(skip));
        wr(OFS_IN_MODE, 32'(im));
        wr(OFS_SPI_MODE, 32'(sm));
        wr(OFS_GPIO_OUT, 32'(gpo));
        wr(OFS_GPIO_DIR, 32'(gdir));
        expect_map();
        repeat (4) @(posedge clk);
        if (sh[SH_ENABLE]) rd(OFS_ROUTE, 32'(er));
        rd(OFS_SEL_HIGH, 32'(sh & 8'hFB));
        // With the crossbar on, analog pads may hold any output value while released.
        m = sh[SH_ENABLE] ? im : '1;
        chk(32'(poe_n), 32'(eoe));
        chk(32'(pout & m), 32'(eo & m));
        chk(32'(ppu), 32'(sh[SH_ENABLE] ?
            im & {NPIN{~sh[SH_WEAKPUD]}} : im));
        chk(32'(fin[SIG_UART_RX]), 32'(sh[SH_ENABLE] & sl[SL_UART] &
            im[UART_RX_PIN] & ext[UART_RX_PIN]));
    endtask : cfg

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 'h2C; a += 4)
            rd(AW'(a), a == 'h0C ? 32'h00FFFFFF : RD_ZERO);
        rd(12'h030, RD_ZERO);
        chk(32'(errv), 32'h1);
        {sl, sh, skip, sm} = {6'h3F, 8'h3F, 24'h0, 2'h1};
        im = '1;
        gpo = '1;
        gdir = '1;
        pat <= '1;
        cfg();
        {sl, sh, skip, sm} = {6'h00, 8'h40, 24'h000004, 2'h0};
        im = 24'hFFFFF7;
        gdir = '0;
        cfg();
        wr(OFS_EV_SEL, 32'h0000020C);
        wr(OFS_EV_MASK, 32'h00000004);
        ext <= ext ^ 24'h00020C;
        for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
        chk(32'(irq), 32'h1);
        rd(OFS_EV_STATUS, 32'h00000204);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        ext <= ext ^ 24'h000200;
        repeat (10) @(posedge clk);
        chk(32'(irq), 32'h0);
        chk(32'(wake), 32'h0);
        rd(OFS_EV_STATUS, 32'h00000200);
        for (int i = 0; i < 44; i++) begin
            skip = NPIN'(rnd());
            sl = 6'(rnd());
            sh = 8'(rnd()) | 8'h40;
            sm = 2'(rnd());
            im = NPIN'(rnd() | rnd());
            gpo = NPIN'(rnd());
            gdir = NPIN'(rnd());
            if (i < 4) {sl, sh, skip, sm} = corner[i];
            pat <= NSIG'(rnd());
            ext <= NPIN'(rnd());
            cfg();
        end
        stop_test();
    end
endmodule : tb

bind pcxb_top pcxb_props i_props (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FUNC_IN(FUNC_IN), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PIN_PULLUP(PIN_PULLUP),
    .IRQ(IRQ), .WAKE(WAKE));
`default_nettype wire
